// ---- mreu_execute_unit.sv ----
/*
 * Memory reference execute unit: runs deposit, load, deposit-zero, the two
 * additions, increment-skip, exclusive OR, AND and skip-if-differ against
 * core memory, updating the working register and program counter.
 * Assumes the operand pointer is stable from start until done, that memory
 * raises mem_done for one cycle per finished access and keeps mem_rdata
 * valid in that cycle, and that no new start arrives while busy is high.
 */
`default_nettype none

module mreu_execute_unit #(
    parameter int WORD_W = mreu_pkg::WORD_W,
    parameter int ADDR_W = mreu_pkg::ADDR_W,
    parameter int PC_W = mreu_pkg::PC_W
) (
    input wire logic clock,
    input wire logic rst,
    // Instruction start pulse from the decoder.
    input wire logic start,
    // Operation to execute, sampled with start.
    input wire logic [3:0] op,
    // Operand pointer from the addressing logic.
    input wire logic [ADDR_W-1:0] operand_pointer,
    // Program counter value already pointing at the next instruction.
    input wire logic [PC_W-1:0] pc_in,
    // Working register preload from the core.
    input wire logic wr_load,
    input wire logic [WORD_W-1:0] wr_load_value,
    // Memory answer.
    input wire logic mem_done,
    input wire logic [WORD_W-1:0] mem_rdata,
    // Memory request.
    output logic mem_req,
    output logic mem_write,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_wdata,
    // Core status and results.
    output logic busy,
    output logic done,
    output logic skip,
    output logic [PC_W-1:0] pc_out,
    output logic [WORD_W-1:0] working_register,
    output logic time_overrun
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // State record
    // ==========================================================
    // Every flip-flop of the unit lives in this record.
    typedef struct packed {
        mreu_pkg::mreu_state_e state;
        logic [3:0] op;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] acc;
        logic [WORD_W-1:0] operand;
        logic [WORD_W-1:0] wdata;
        logic req;
        logic wr;
        logic busy;
        logic done;
        logic skip;
        logic [PC_W-1:0] pc;
        logic [mreu_pkg::CNT_W-1:0] cycles;
        logic overrun;
    } mreu_state_s;

    // Current and next state.
    mreu_state_s cur;
    mreu_state_s next_cur;

    // Arithmetic helpers; raw_sum is sized one bit wider to keep the carry.
    logic [WORD_W:0] raw_sum;
    logic [WORD_W-1:0] ones_sum;
    logic [WORD_W-1:0] inc_sum;
    logic [mreu_pkg::CNT_W-1:0] limit;

    // ==========================================================
    // Arithmetic
    // ==========================================================
    // Sum of operand and working register, plus the ones add wrap.
    always_comb begin
        raw_sum = {1'b0, cur.operand} + {1'b0, cur.acc};
        // End-around carry goes back into the low bit.
        ones_sum = raw_sum[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, raw_sum[WORD_W]};
        // Increment wraps modulo the word, no carry kept.
        inc_sum = cur.operand + mreu_pkg::WORD_ONE;
        // Increment-skip has the longer budget, all others the shorter.
        if (cur.op == mreu_pkg::MREU_OP_INC_SKIP) begin
            limit = mreu_pkg::CNT_W'(mreu_pkg::CYC_LONG);
        end else begin
            limit = mreu_pkg::CNT_W'(mreu_pkg::CYC_SHORT);
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Walks one instruction through read, compute, write and finish.
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.skip = 1'b0;
        next_cur.req = 1'b0;
        // Elapsed cycles count while busy, for the time budget monitor.
        if (cur.busy) begin
            next_cur.cycles = cur.cycles + mreu_pkg::CNT_ONE;
        end
        // A preload from the core may change the register while idle.
        if (wr_load && !cur.busy) begin
            next_cur.acc = wr_load_value;
        end
        unique case (cur.state)
            mreu_pkg::MREU_ST_IDLE: begin
                if (start) begin
                    next_cur.op = op;
                    next_cur.addr = operand_pointer;
                    next_cur.pc = pc_in;
                    next_cur.busy = 1'b1;
                    next_cur.cycles = mreu_pkg::CNT_ZERO;
                    next_cur.overrun = 1'b0;
                    if (op == mreu_pkg::MREU_OP_DEPOSIT) begin
                        // Working register goes straight out.
                        next_cur.wdata = cur.acc;
                        next_cur.state = mreu_pkg::MREU_ST_WRITE;
                    end else if (op == mreu_pkg::MREU_OP_DEPOSIT_ZERO) begin
                        // Zero goes out, no register changes.
                        next_cur.wdata = mreu_pkg::WORD_ZERO;
                        next_cur.state = mreu_pkg::MREU_ST_WRITE;
                    end else begin
                        next_cur.state = mreu_pkg::MREU_ST_READ;
                    end
                end
            end
            mreu_pkg::MREU_ST_READ: begin
                // One-cycle read request.
                next_cur.req = 1'b1;
                next_cur.wr = 1'b0;
                next_cur.state = mreu_pkg::MREU_ST_WAIT_READ;
            end
            mreu_pkg::MREU_ST_WAIT_READ: begin
                if (mem_done) begin
                    next_cur.operand = mem_rdata;
                    next_cur.state = mreu_pkg::MREU_ST_FINISH;
                end
            end
            mreu_pkg::MREU_ST_WRITE: begin
                // One-cycle write request.
                next_cur.req = 1'b1;
                next_cur.wr = 1'b1;
                next_cur.state = mreu_pkg::MREU_ST_WAIT_WRITE;
            end
            mreu_pkg::MREU_ST_WAIT_WRITE: begin
                if (mem_done) begin
                    next_cur.busy = 1'b0;
                    next_cur.done = 1'b1;
                    next_cur.wr = 1'b0;
                    next_cur.state = mreu_pkg::MREU_ST_IDLE;
                    // Increment-skip skips once its write has landed, if the word written back is zero.
                    if (cur.op == mreu_pkg::MREU_OP_INC_SKIP
                        && cur.wdata == mreu_pkg::WORD_ZERO) begin
                        next_cur.skip = 1'b1;
                        next_cur.pc = cur.pc + mreu_pkg::PC_ONE;
                    end
                end
            end
            mreu_pkg::MREU_ST_FINISH: begin
                // Operand is in hand: compute and retire or write back.
                next_cur.busy = 1'b0;
                next_cur.done = 1'b1;
                next_cur.state = mreu_pkg::MREU_ST_IDLE;
                unique case (cur.op)
                    mreu_pkg::MREU_OP_LOAD: begin
                        next_cur.acc = cur.operand;
                    end
                    mreu_pkg::MREU_OP_ONES_ADD: begin
                        next_cur.acc = ones_sum;
                    end
                    mreu_pkg::MREU_OP_TWOS_ADD: begin
                        next_cur.acc = raw_sum[WORD_W-1:0];
                    end
                    mreu_pkg::MREU_OP_XOR: begin
                        next_cur.acc = cur.acc ^ cur.operand;
                    end
                    mreu_pkg::MREU_OP_AND: begin
                        next_cur.acc = cur.acc & cur.operand;
                    end
                    mreu_pkg::MREU_OP_SKIP_DIFFER: begin
                        // Compare only; neither operand is written.
                        if (cur.acc != cur.operand) begin
                            next_cur.skip = 1'b1;
                            next_cur.pc = cur.pc + mreu_pkg::PC_ONE;
                        end
                    end
                    mreu_pkg::MREU_OP_INC_SKIP: begin
                        // Not finished yet: write the incremented word back.
                        next_cur.busy = 1'b1;
                        next_cur.done = 1'b0;
                        next_cur.wdata = inc_sum;
                        next_cur.state = mreu_pkg::MREU_ST_WRITE;
                    end
                    default: begin
                        // Codes outside this group retire with no effect.
                        next_cur.acc = cur.acc;
                    end
                endcase
            end
            default: begin
                // Illegal state code falls back to idle.
                next_cur.state = mreu_pkg::MREU_ST_IDLE;
                next_cur.busy = 1'b0;
            end
        endcase
        // Budget holds for memory without parity; a slower memory is flagged.
        if (next_cur.done && cur.cycles >= limit) begin
            next_cur.overrun = 1'b1;
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Registers the whole record; reset puts constants everywhere.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // All outputs come straight from the record.
    assign mem_req = cur.req;
    assign mem_write = cur.wr;
    assign mem_addr = cur.addr;
    assign mem_wdata = cur.wdata;
    assign busy = cur.busy;
    assign done = cur.done;
    assign skip = cur.skip;
    assign pc_out = cur.pc;
    assign working_register = cur.acc;
    assign time_overrun = cur.overrun;

endmodule // mreu_execute_unit

`default_nettype wire

// ---- mreu_execute_unit_monitor.sv ----
/*
 * Assertions on the execute unit's ports.
 * Assumes one clock and the active-high asynchronous reset.
 */
`default_nettype none

// ==========================================================
// Checker
// ==========================================================
module mreu_execute_unit_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [3:0] op,
    input wire logic [14:0] operand_pointer,
    input wire logic [14:0] pc_in,
    input wire logic mem_done,
    input wire logic [17:0] mem_rdata,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [14:0] mem_addr,
    input wire logic [17:0] mem_wdata,
    input wire logic done,
    input wire logic busy,
    input wire logic skip,
    input wire logic [14:0] pc_out,
    input wire logic [17:0] working_register
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] op_c; // Operation taken.
    logic [14:0] pc_c; // Next-instruction address taken.
    logic [14:0] a_c; // Operand pointer taken.
    logic [17:0] w_c; // Working register at start.
    logic [17:0] r_c; // mem_rdata at the last mem_done, read or write.

    // Keeps what each instruction started with.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {op_c, pc_c, a_c, w_c, r_c} <= '0;
        end else begin
            if (start && !busy) begin
                op_c <= op;
                pc_c <= pc_in;
                a_c <= operand_pointer;
                w_c <= working_register;
            end
            if (mem_done) begin
                r_c <= mem_rdata;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_busy; start && !busy |=> busy; endproperty
    a_busy: assert property (p_busy) else $error("busy missing after start");
    property p_addr; mem_req |-> mem_addr == a_c; endproperty
    a_addr: assert property (p_addr) else $error("wrong memory address");
    property p_dep; mem_req && op_c == mreu_pkg::MREU_OP_DEPOSIT |-> mem_wdata == w_c; endproperty
    a_dep: assert property (p_dep) else $error("deposit data wrong");
    property p_zero; mem_req && op_c == mreu_pkg::MREU_OP_DEPOSIT_ZERO |-> mem_write
        && mem_wdata == 18'h00000; endproperty
    a_zero: assert property (p_zero) else $error("zero deposit wrong");
    property p_load; done && op_c == mreu_pkg::MREU_OP_LOAD |-> working_register == r_c;
    endproperty
    a_load: assert property (p_load) else $error("load result wrong");
    property p_and; done && op_c == mreu_pkg::MREU_OP_AND |-> working_register == (w_c & r_c);
    endproperty
    a_and: assert property (p_and) else $error("and result wrong");
    property p_xor; done && op_c == mreu_pkg::MREU_OP_XOR |-> working_register == (w_c ^ r_c);
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");
    property p_differ; done && op_c == mreu_pkg::MREU_OP_SKIP_DIFFER |-> skip == (w_c != r_c);
    endproperty
    a_differ: assert property (p_differ) else $error("compare skip wrong");
    property p_inc; mem_req && mem_write && op_c == mreu_pkg::MREU_OP_INC_SKIP |->
        mem_wdata == r_c + 18'h00001; endproperty
    a_inc: assert property (p_inc) else $error("increment write-back wrong");
    property p_pc; done |-> pc_out == pc_c + {14'h0000, skip}; endproperty
    a_pc: assert property (p_pc) else $error("program counter wrong");
    property p_skip; skip |-> done ##1 !skip; endproperty
    a_skip: assert property (p_skip) else $error("skip pulse wrong");
endmodule // mreu_execute_unit_monitor

bind mreu_execute_unit mreu_execute_unit_monitor mon (.clock, .rst, .start, .op,
    .operand_pointer, .pc_in, .mem_done, .mem_rdata, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .done, .busy, .skip, .pc_out, .working_register);

`default_nettype wire

// ---- mreu_execute_unit_test.sv ----
/*
 * Self-checking bench for the execute unit with a core memory model.
 * Assumes the memory model and the bound checker are compiled first.
 */
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

// ==========================================================
// Bench
// ==========================================================
module mreu_execute_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst, start, wr_load, mem_done, mem_req, mem_write;
    logic busy, done, skip, time_overrun;
    logic [3:0] op, lat;
    logic [14:0] operand_pointer, pc_in, mem_addr, pc_out;
    logic [17:0] wr_load_value, mem_rdata, mem_wdata, working_register;
    int err_count = 0;
    int tests_run = 0;

    mreu_execute_unit dut (.clock, .rst, .start, .op, .operand_pointer, .pc_in, .wr_load,
        .wr_load_value, .mem_done, .mem_rdata, .mem_req, .mem_write, .mem_addr, .mem_wdata,
        .busy, .done, .skip, .pc_out, .working_register, .time_overrun);
    mreu_memory_model mdl (.clock, .lat, .mem_req, .mem_write, .mem_addr, .mem_wdata,
        .mem_done, .mem_rdata);

    // Prints the counts and the verdict, then stops.
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Preloads the working register while idle.
    task automatic wl(input logic [17:0] v);
        @(negedge clock) wr_load = 1'b1;
        wr_load_value = v;
        @(negedge clock) wr_load = 1'b0;
    endtask

    // Runs one instruction and waits, bounded, for its done pulse.
    task automatic exec(input logic [3:0] o, input logic [14:0] a, input logic [14:0] pc);
        int n = 0;
        @(negedge clock) {op, operand_pointer, pc_in, start} = {o, a, pc, 1'b1};
        @(negedge clock) start = 1'b0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge clock) n++;
        end
        if (n >= 200) begin
            err_count++;
            report_and_stop();
        end
    endtask

    // Deposit, load and deposit-zero.
    task automatic t_transfer();
        wl(18'h2A5C3);
        exec(mreu_pkg::MREU_OP_DEPOSIT, 15'h0001, 15'h0100);
        `CHK(mdl.mem[1], 18'h2A5C3)
        mdl.mem[2] = 18'h15A3C;
        exec(mreu_pkg::MREU_OP_LOAD, 15'h0002, 15'h0101);
        `CHK(working_register, 18'h15A3C)
        `CHK(mdl.mem[2], 18'h15A3C)
        exec(mreu_pkg::MREU_OP_DEPOSIT_ZERO, 15'h0001, 15'h0102);
        `CHK(mdl.mem[1], 18'h00000)
        `CHK(working_register, 18'h15A3C)
        `CHK(pc_out, 15'h0102)
        `CHK(time_overrun, 1'b0)
        $display("transfer test ended");
    endtask

    // Both additions on a carry out of the sign bit.
    task automatic t_add();
        mdl.mem[3] = 18'h20001;
        wl(18'h20000);
        exec(mreu_pkg::MREU_OP_ONES_ADD, 15'h0003, 15'h0110);
        `CHK(working_register, 18'h00002)
        wl(18'h20000);
        exec(mreu_pkg::MREU_OP_TWOS_ADD, 15'h0003, 15'h0111);
        `CHK(working_register, 18'h00001)
        $display("add test ended");
    endtask

    // Increment-skip on wrap to zero and on a plain count, slow memory.
    task automatic t_inc_skip();
        lat = 4'h3;
        mdl.mem[4] = 18'h3FFFF;
        mdl.mem[5] = 18'h00005;
        wl(18'h12345);
        exec(mreu_pkg::MREU_OP_INC_SKIP, 15'h0004, 15'h0200);
        `CHK(mdl.mem[4], 18'h00000)
        `CHK(skip, 1'b1)
        `CHK(pc_out, 15'h0201)
        exec(mreu_pkg::MREU_OP_INC_SKIP, 15'h0005, 15'h0300);
        `CHK(mdl.mem[5], 18'h00006)
        `CHK(skip, 1'b0)
        `CHK(pc_out, 15'h0300)
        `CHK(working_register, 18'h12345)
        `CHK(time_overrun, 1'b0)
        lat = 4'h0;
        $display("increment test ended");
    endtask

    // Masking with AND and exclusive OR on all 18 bits.
    task automatic t_logic();
        mdl.mem[6] = 18'h16EF5;
        wl(18'h00FFF);
        exec(mreu_pkg::MREU_OP_AND, 15'h0006, 15'h0120);
        `CHK(working_register, 18'h00EF5)
        wl(18'h00FFF);
        exec(mreu_pkg::MREU_OP_XOR, 15'h0006, 15'h0121);
        `CHK(working_register, 18'h1610A)
        `CHK(mdl.mem[6], 18'h16EF5)
        $display("logic test ended");
    endtask

    // Compare on equal and on a one-bit difference.
    task automatic t_skip_differ();
        mdl.mem[7] = 18'h0ABCD;
        wl(18'h0ABCD);
        exec(mreu_pkg::MREU_OP_SKIP_DIFFER, 15'h0007, 15'h0400);
        `CHK(skip, 1'b0)
        mdl.mem[7] = 18'h0ABCC;
        exec(mreu_pkg::MREU_OP_SKIP_DIFFER, 15'h0007, 15'h0400);
        `CHK(skip, 1'b1)
        `CHK(pc_out, 15'h0401)
        `CHK(working_register, 18'h0ABCD)
        `CHK(mdl.mem[7], 18'h0ABCC)
        $display("compare test ended");
    endtask

    // Reset in mid-instruction returns every output to zero, then work resumes.
    task automatic t_reset();
        @(negedge clock) {op, operand_pointer, pc_in, start} =
            {mreu_pkg::MREU_OP_LOAD, 15'h0002, 15'h0500, 1'b1};
        @(negedge clock) start = 1'b0;
        `CHK(busy, 1'b1)
        rst = 1'b1;
        @(negedge clock) rst = 1'b0;
        `CHK(busy, 1'b0)
        `CHK(mem_req, 1'b0)
        `CHK(working_register, 18'h00000)
        `CHK(pc_out, 15'h0000)
        @(negedge clock);
        `CHK({busy, done, skip, mem_req, mem_write}, 5'h00)
        exec(mreu_pkg::MREU_OP_LOAD, 15'h0002, 15'h0501);
        `CHK(working_register, 18'h15A3C)
        $display("reset test ended");
    endtask

    // Slow memory overruns the budget; an undecoded code retires with no effect.
    task automatic t_slow();
        lat = 4'hF;
        mdl.mem[8] = 18'h00777;
        exec(mreu_pkg::MREU_OP_LOAD, 15'h0008, 15'h0600);
        `CHK(working_register, 18'h00777)
        `CHK(time_overrun, 1'b1)
        lat = 4'h0;
        exec(4'hF, 15'h0008, 15'h0601);
        `CHK(working_register, 18'h00777)
        `CHK(skip, 1'b0)
        `CHK(pc_out, 15'h0601)
        `CHK(time_overrun, 1'b0)
        $display("slow memory test ended");
    endtask

    // Free-running processor clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        {start, wr_load, op, lat, operand_pointer, pc_in, wr_load_value} = '0;
        repeat (16) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        t_transfer();
        t_reset();
        t_add();
        t_inc_skip();
        t_logic();
        t_skip_differ();
        t_slow();
        report_and_stop();
    end
endmodule // mreu_execute_unit_test

`undef CHK
`default_nettype wire

// ---- mreu_memory_model.sv ----
/*
 * Core memory model for the execute unit bench: 16 words, adjustable latency.
 * Assumes mem_addr holds from request until done, as the unit promises.
 */
`default_nettype none

// ==========================================================
// Memory model
// ==========================================================
module mreu_memory_model (
    input wire logic clock,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [14:0] mem_addr,
    input wire logic [17:0] mem_wdata,
    output logic mem_done,
    output logic [17:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [17:0] mem [16]; // Storage, also written by the bench.
    logic [3:0] cnt = 4'h0; // Cycles left before the answer, known from time zero.
    logic [17:0] wd; // Write data kept from the request.
    logic fire; // The access finishes at this edge.
    assign fire = (mem_req && lat == 4'h0) || cnt == 4'h1;

    // Answers each request once; stale read data is inverted every cycle, so it matches the stored word on alternate cycles.
    always @(posedge clock) begin
        mem_done <= fire;
        mem_rdata <= ~mem_rdata;
        if (mem_req) begin
            wd <= mem_wdata;
            cnt <= lat;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        if (fire && mem_write) begin
            mem[mem_addr[3:0]] <= mem_req ? mem_wdata : wd;
        end else if (fire) begin
            mem_rdata <= mem[mem_addr[3:0]];
        end
    end
endmodule // mreu_memory_model

`default_nettype wire

// ---- mreu_pkg.sv ----
/*
 * Shared constants and types for the memory reference execute unit.
 * Assumes a single 10 MHz processor clock and a core memory that answers
 * one read or one write per request with a done pulse.
 */
`default_nettype none

package mreu_pkg;
    // ==========================================================
    // Word format
    // ==========================================================
    // Data word width; the sign-first bit 0 is our MSB (sign).
    localparam int WORD_W = 18;
    // Memory address width seen by this unit.
    localparam int ADDR_W = 15;
    // Program counter width.
    localparam int PC_W = 15;

    // ==========================================================
    // Timing
    // ==========================================================
    // Processor clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 100;
    // Worst-case time of a two-cycle instruction in nanoseconds.
    localparam int TIME_SHORT_NS = 1600;
    // Worst-case time of the increment-skip instruction in nanoseconds.
    localparam int TIME_LONG_NS = 2400;
    // Longest times round down to whole cycles.
    localparam int CYC_SHORT = TIME_SHORT_NS / CLK_PERIOD_NS;
    localparam int CYC_LONG = TIME_LONG_NS / CLK_PERIOD_NS;
    // Width of the elapsed-cycle counter.
    localparam int CNT_W = 8;

    // ==========================================================
    // Operation codes presented by the decoder
    // ==========================================================
    typedef enum logic [3:0] {
        MREU_OP_DEPOSIT = 4'h0,
        MREU_OP_LOAD = 4'h1,
        MREU_OP_DEPOSIT_ZERO = 4'h2,
        MREU_OP_ONES_ADD = 4'h3,
        MREU_OP_TWOS_ADD = 4'h4,
        MREU_OP_INC_SKIP = 4'h5,
        MREU_OP_XOR = 4'h6,
        MREU_OP_AND = 4'h7,
        MREU_OP_SKIP_DIFFER = 4'h8
    } mreu_op_e;

    // Sequencer states.
    typedef enum logic [2:0] {
        MREU_ST_IDLE = 3'h0,
        MREU_ST_READ = 3'h1,
        MREU_ST_WAIT_READ = 3'h2,
        MREU_ST_WRITE = 3'h3,
        MREU_ST_WAIT_WRITE = 3'h4,
        MREU_ST_FINISH = 3'h5
    } mreu_state_e;

    // Zero and one constants.
    localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;
    localparam logic [WORD_W-1:0] WORD_ONE = 18'h00001;
    localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
endpackage : mreu_pkg

`default_nettype wire
